// ### rtl/cssel_pkg.sv
// Constants, types and decode helpers for the clock source start-up block
package cssel_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DLY_SHORT_US  = 4100;
  localparam int unsigned DLY_LONG_US   = 65000;
  // Both times round down to whole cycles
  localparam int unsigned DLY_SHORT_CYC = (DLY_SHORT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned DLY_LONG_CYC  = (DLY_LONG_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned DLY_W         = 23;

  localparam logic [4:0] CK_WAKE_SHORT = 5'h06;
  localparam logic [4:0] CK_WAKE_LONG  = 5'h12;

  localparam logic [11:0] ADDR_TRIM = 12'h000;
  localparam logic [11:0] ADDR_OPT  = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;

  localparam logic [3:0] CLOCK_SOURCE_SELECT_EXT    = 4'h0;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_IRC_LO = 4'h1;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_IRC_HI = 4'h4;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_XRC_LO = 4'h5;
  localparam logic [3:0] CLOCK_SOURCE_SELECT_XRC_HI = 4'h8;

  localparam logic [1:0] SUT_NONE  = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG  = 2'h2;
  localparam logic [1:0] SUT_ALT   = 2'h3;

  typedef struct packed {
    logic       legacy;
    logic       osc_opt;
    logic [1:0] startup_time_select;
    logic [3:0] clock_source_select;
  } cssel_opt_t;

  localparam logic [7:0] OPT_RST  = 8'h21;
  localparam logic [7:0] TRIM_RST = 8'h00;

  typedef enum logic [2:0] {
    SRC_EXT = 3'b001,
    SRC_IRC = 3'b010,
    SRC_XRC = 3'b100
  } cssel_src_t;

  typedef enum logic [3:0] {
    ST_OSC   = 4'b0001,
    ST_DLY   = 4'b0010,
    ST_RUN   = 4'b0100,
    ST_SLEEP = 4'b1000
  } cssel_state_t;

  typedef struct packed {
    cssel_src_t src;
    logic [1:0] band;
    logic       bad;
  } cssel_dec_t;

  typedef struct packed {
    logic [4:0] wake_ck;
    logic [1:0] dly;
    logic       bad;
  } cssel_sut_t;

  // Unsupported codes fall back to the 1 MHz internal RC and flag an error
  function automatic cssel_dec_t cssel_decode(input logic [3:0] clock_source_select);
    cssel_dec_t d;
    d = '{src: SRC_IRC, band: 2'h0, bad: 1'b0};
    if (clock_source_select == CLOCK_SOURCE_SELECT_EXT)
      d.src = SRC_EXT;
    else if (clock_source_select >= CLOCK_SOURCE_SELECT_IRC_LO && clock_source_select <= CLOCK_SOURCE_SELECT_IRC_HI)
      d.band = 2'(clock_source_select - CLOCK_SOURCE_SELECT_IRC_LO);
    else if (clock_source_select >= CLOCK_SOURCE_SELECT_XRC_LO && clock_source_select <= CLOCK_SOURCE_SELECT_XRC_HI)
    begin
      d.src  = SRC_XRC;
      d.band = 2'(clock_source_select - CLOCK_SOURCE_SELECT_XRC_LO);
    end
    else
      d.bad = 1'b1;
    return d;
  endfunction

  // Reserved start-up codes use the long delay as the safe choice
  function automatic cssel_sut_t cssel_sut(input cssel_src_t src,
                                           input logic [1:0] startup_time_select);
    cssel_sut_t s;
    s = '{wake_ck: CK_WAKE_SHORT, dly: startup_time_select, bad: 1'b0};
    if (src == SRC_XRC)
    begin
      if (startup_time_select == SUT_ALT)
        s.dly = SUT_SHORT;
      else
        s.wake_ck = CK_WAKE_LONG;
    end
    else if (startup_time_select == SUT_ALT)
    begin
      s.dly = SUT_LONG;
      s.bad = 1'b1;
    end
    return s;
  endfunction

endpackage

// ### rtl/cssel_top.sv
// Clock source selection, start-up sequencer and oscillator trim register
// What this block does
// - Codes 0101..1000 select external RC bands
// - External RC: 18 cycles, delay none/short/long; 11: 6+short
// - Codes 0001..0100 select internal RC 1/2/4/8 MHz
// - Internal RC: 6 cycles, delay none/short/long, 11 reserved
// - Reset loads factory calibration byte into trim
// - Trim value raises internal RC frequency monotonically
// - Trim register absent in legacy compatibility mode
// - Watchdog oscillator still times the reset time-out; here the time-out counts pclk cycles instead
// - Code 0000 takes clock from clock input pin
// - External clock: 6 cycles, delay none/short/long, 11 reserved
// - Delivered setting: internal 1 MHz, longest delay
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cssel_top
  import cssel_pkg::*;
#(
  parameter int unsigned DLY_SHORT = DLY_SHORT_CYC,
  parameter int unsigned DLY_LONG  = DLY_LONG_CYC
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  calib_byte_hi,
  input  wire logic        clock_input_pin_tick,
  input  wire logic        irc_tick,
  input  wire logic        xrc_tick,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  output logic             core_clk_en,
  output logic             core_reset_n,
  output logic             ext_clk_sel,
  output logic             irc_enable,
  output logic             xrc_enable,
  output logic      [1:0]  freq_band,
  output logic             osc_cap_en,
  output logic      [7:0]  trim_value,
  output logic             timeout_on_wdosc
);

  cssel_opt_t   opt_r,   opt_nxt;
  logic [7:0]   trim_r,  trim_nxt;
  logic         load_r,  load_nxt;
  logic [31:0]  rdata_r, rdata_nxt;
  cssel_state_t state_r, state_nxt;
  logic [4:0]   ck_r,    ck_nxt;
  logic [DLY_W-1:0] dly_r, dly_nxt;
  logic         frst_r,  frst_nxt;

  cssel_dec_t   dec;
  cssel_sut_t   startup_time_select;
  logic         sel_tick;
  logic [DLY_W-1:0] dly_need;
  logic         wr_acc;
  logic         rd_acc;
  logic         hit;

  assign dec = cssel_decode(opt_r.clock_source_select);
  assign startup_time_select = cssel_sut(dec.src, opt_r.startup_time_select);

  always_comb
  begin
    unique case (dec.src)
      SRC_EXT: sel_tick = clock_input_pin_tick;
      SRC_IRC: sel_tick = irc_tick;
      SRC_XRC: sel_tick = xrc_tick;
      default: sel_tick = 1'b0;
    endcase
  end

  always_comb
  begin
    unique case (startup_time_select.dly)
      SUT_SHORT: dly_need = DLY_W'(DLY_SHORT);
      SUT_LONG:  dly_need = DLY_W'(DLY_LONG);
      default:   dly_need = '0;
    endcase
  end

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~pwrite;
  assign hit = ((paddr == ADDR_TRIM) & ~opt_r.legacy) |
               (paddr == ADDR_OPT) | (paddr == ADDR_STAT);
  // Zero wait states: every register answers in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = rdata_r;

  // Register file; read data is staged in the setup cycle
  always_comb
  begin
    opt_nxt   = opt_r;
    trim_nxt  = trim_r;
    load_nxt  = 1'b0;
    rdata_nxt = rdata_r;
    if (load_r)
      trim_nxt = calib_byte_hi;
    else if (wr_acc && paddr == ADDR_TRIM && !opt_r.legacy)
      trim_nxt = pwdata[7:0];
    if (wr_acc && paddr == ADDR_OPT)
      opt_nxt = cssel_opt_t'(pwdata[7:0]);
    if (rd_acc && !penable)
    begin
      rdata_nxt = '0;
      if (paddr == ADDR_TRIM && !opt_r.legacy)
        rdata_nxt[7:0] = trim_r;
      else if (paddr == ADDR_OPT)
        rdata_nxt[7:0] = opt_r;
      else if (paddr == ADDR_STAT)
        rdata_nxt[11:0] = {frst_r, state_r, dec.src, dec.band,
                           dec.bad, startup_time_select.bad};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opt_r   <= cssel_opt_t'(OPT_RST);
      trim_r  <= TRIM_RST;
      load_r  <= 1'b1;
      rdata_r <= '0;
    end
    else
    begin
      opt_r   <= opt_nxt;
      trim_r  <= trim_nxt;
      load_r  <= load_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    ck_nxt    = ck_r;
    dly_nxt   = dly_r;
    frst_nxt  = frst_r;
    unique case (state_r)
      ST_OSC:
        if (sel_tick)
        begin
          if (ck_r == startup_time_select.wake_ck - 5'h01)
          begin
            ck_nxt  = '0;
            dly_nxt = '0;
            if (frst_r && dly_need != '0)
              state_nxt = ST_DLY;
            else
            begin
              state_nxt = ST_RUN;
              frst_nxt  = 1'b0;
            end
          end
          else
            ck_nxt = ck_r + 5'h01;
        end
      // time-out on pclk, standing for watchdog oscillator
      ST_DLY:
        if (dly_r == dly_need - DLY_W'(1))
        begin
          state_nxt = ST_RUN;
          frst_nxt  = 1'b0;
        end
        else
          dly_nxt = dly_r + DLY_W'(1);
      ST_RUN:
        if (sleep_req)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (wake_req)
        begin
          state_nxt = ST_OSC;
          ck_nxt    = '0;
        end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_OSC;
      ck_r    <= '0;
      dly_r   <= '0;
      frst_r  <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      ck_r    <= ck_nxt;
      dly_r   <= dly_nxt;
      frst_r  <= frst_nxt;
    end
  end

  // Oscillator controls follow the decoded source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_clk_en      <= 1'b0;
      core_reset_n     <= 1'b0;
      ext_clk_sel      <= 1'b0;
      irc_enable       <= 1'b0;
      xrc_enable       <= 1'b0;
      freq_band        <= '0;
      osc_cap_en       <= 1'b0;
      timeout_on_wdosc <= 1'b1;
    end
    else
    begin
      core_clk_en      <= (state_nxt == ST_RUN);
      core_reset_n     <= ~frst_nxt;
      ext_clk_sel      <= (dec.src == SRC_EXT);
      irc_enable       <= (dec.src == SRC_IRC) & (state_nxt != ST_SLEEP);
      xrc_enable       <= (dec.src == SRC_XRC) & (state_nxt != ST_SLEEP);
      freq_band        <= dec.band;
      osc_cap_en       <= opt_r.osc_opt & (dec.src != SRC_IRC);
      timeout_on_wdosc <= 1'b1;
    end
  end

  assign trim_value = trim_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_tick;
    state_r == ST_OSC && sel_tick && ck_r == startup_time_select.wake_ck - 5'h01;
  endsequence

  chk_xrc_band: assert property (
    opt_r.clock_source_select == CLOCK_SOURCE_SELECT_XRC_HI && state_r == ST_RUN && !sleep_req |=>
      xrc_enable && freq_band == 2'h3)
    else $error("external RC top band not decoded");
  chk_xrc_wake: assert property (
    (dec.src == SRC_XRC && opt_r.startup_time_select != SUT_ALT) and s_last_tick |->
      ck_r == 5'h11)
    else $error("external RC wake count not 18");
  chk_irc_band: assert property (
    opt_r.clock_source_select == CLOCK_SOURCE_SELECT_IRC_HI && state_r == ST_RUN && !sleep_req |=>
      irc_enable && freq_band == 2'h3)
    else $error("internal RC 8 MHz not decoded");
  chk_irc_wake: assert property (
    (dec.src == SRC_IRC) and s_last_tick |-> ck_r == 5'h05)
    else $error("internal RC wake count not 6");
  chk_trim_load: assert property (
    load_r |=> trim_r == $past(calib_byte_hi))
    else $error("calibration byte not loaded");
  chk_trim_out: assert property (
    wr_acc && paddr == ADDR_TRIM && !opt_r.legacy && !load_r |=>
      trim_value == $past(pwdata[7:0]))
    else $error("trim write not applied");
  chk_legacy_wr: assert property (
    wr_acc && opt_r.legacy && !load_r |=> $stable(trim_r))
    else $error("trim changed in legacy mode");
  chk_ext_pin: assert property (
    opt_r.clock_source_select == CLOCK_SOURCE_SELECT_EXT ##1 $stable(opt_r) |-> ext_clk_sel)
    else $error("clock pin path not selected");
  chk_dly_hold: assert property (
    s_last_tick and (frst_r && dly_need != '0) |=>
      (state_r == ST_DLY && !core_reset_n) [*2])
    else $error("reset delay skipped");
  chk_xrc_alt: assert property (
    (dec.src == SRC_XRC && opt_r.startup_time_select == SUT_ALT) and s_last_tick |->
      ck_r == 5'h05)
    else $error("external RC short wake count not 6");
  chk_ext_wake: assert property (
    (dec.src == SRC_EXT) and s_last_tick |-> ck_r == 5'h05)
    else $error("external clock wake count not 6");
  chk_legacy_err: assert property (
    psel && penable && paddr == ADDR_TRIM && opt_r.legacy |-> pslverr)
    else $error("trim access in legacy mode not refused");
  chk_sleep_stop: assert property (
    state_r == ST_SLEEP |-> !core_clk_en && !irc_enable && !xrc_enable)
    else $error("clocks still running in sleep");

endmodule
`default_nettype wire

// ### dv/cssel_osc_model.sv
// Tick source model for the clock pin and both RC oscillators
`timescale 1ns/1ps
`default_nettype none
module cssel_osc_model
#(
  parameter int unsigned P_EXT = 2,
  parameter int unsigned P_IRC = 3,
  parameter int unsigned P_XRC = 4
)
(
  input  wire logic pclk,
  input  wire logic irc_enable,
  input  wire logic xrc_enable,
  output logic      clock_input_pin_tick,
  output logic      irc_tick,
  output logic      xrc_tick
);
  int unsigned ce = 0;
  int unsigned ci = 0;
  int unsigned cx = 0;
  // steady pin rate
  // Rates never step, so no reset hold is ever owed
  always @(posedge pclk)
  begin
    ce <= (ce + 1) % P_EXT;
    ci <= irc_enable ? (ci + 1) % P_IRC : 0;
    cx <= xrc_enable ? (cx + 1) % P_XRC : 0;
  end
  assign clock_input_pin_tick = (ce == P_EXT - 1);
  // Stopped oscillators give no ticks at all
  assign irc_tick = irc_enable && (ci == P_IRC - 1);
  assign xrc_tick = xrc_enable && (cx == P_XRC - 1);
endmodule
`default_nettype wire

// ### dv/cssel_tb_top.sv
// Self-checking bench for the clock source start-up block
`timescale 1ns/1ps
`default_nettype none
module cssel_tb_top;
  import cssel_pkg::*;
  localparam int unsigned DL = 50;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0]  calib_byte_hi = '0;
  logic        sleep_req = 0;
  logic        wake_req = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clock_input_pin_tick;
  logic        irc_tick;
  logic        xrc_tick;
  logic        core_clk_en;
  logic        core_reset_n;
  logic        ext_clk_sel;
  logic        irc_enable;
  logic        xrc_enable;
  logic [1:0]  freq_band;
  logic        osc_cap_en;
  logic [7:0]  trim_value;
  logic        timeout_on_wdosc;
  logic [32:0] exp_q[$];
  logic [32:0] r;
  logic [31:0] v;
  logic [7:0]  opt;
  int          fail_count = 0;
  int          total_checks = 0;
  int          seed = 32'hd31dc66b;
  int          c;
  int          n;
  int          p;

  always #5 pclk = ~pclk;

  cssel_top #(.DLY_SHORT(20), .DLY_LONG(DL)) dut (.*);
  cssel_osc_model model (.*);

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmp_rd(input logic [32:0] e, input logic w);
    cmp("pslverr", e[32], pslverr);
    if (!w)
      cmp("prdata", e[31:0], prdata);
  endtask

  // Expected response is queued; reads carry it in d
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic err);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({err, w ? 32'h0 : d});
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    k = 0;
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    cmp("wait states", 0, k);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  always @(posedge pclk)
    if (psel && penable && pready)
    begin
      r = exp_q.pop_front();
      cmp_rd(r, pwrite);
    end

  task automatic wait_clk(input logic lv, output int cnt);
    cnt = 0;
    while (core_clk_en !== lv && cnt < 1000)
    begin
      @(posedge pclk);
      #1;
      cnt++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #300us;
    fail_count++;
    $display("wrong value watchdog expected done seen hang");
    end_sim();
  end

  initial
  begin
    calib_byte_hi <= 8'($random(seed));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    wait_clk(1, c);
    cmp("start cycles", 1, c >= DL + 12 && c <= DL + 26);
    cmp("core_reset_n", 1, core_reset_n);
    cmp("trim_value", calib_byte_hi, trim_value);
    cmp("timeout_on_wdosc", 1, timeout_on_wdosc);
    @(posedge pclk);
    apb(0, ADDR_OPT, 32'h21, 0);
    apb(0, ADDR_TRIM, calib_byte_hi, 0);
    apb(0, ADDR_STAT, {20'h0, 1'b0, ST_RUN, SRC_IRC, 4'h0}, 0);
    v = $random(seed);
    // Upper bits must drop; no nonvolatile writes run here
    apb(1, ADDR_TRIM, v, 0);
    apb(0, ADDR_TRIM, v[7:0], 0);
    cmp("trim_value", v[7:0], trim_value);
    apb(1, ADDR_OPT, 32'hA1, 0);
    apb(0, ADDR_TRIM, 32'h0, 1);
    apb(1, ADDR_TRIM, 32'h5A, 1);
    apb(1, ADDR_OPT, 32'h21, 0);
    apb(0, ADDR_TRIM, v[7:0], 0);
    apb(0, 12'h00C, 32'h0, 1);
    for (int k = 0; k < 10; k++)
    begin
      opt = (k == 9) ? 8'h35 : 8'(k);
      // option bit clear for internal RC
      if (k == 0 || k > 4)
        opt[6] = 1'($random(seed));
      apb(1, ADDR_OPT, opt, 0);
      apb(0, ADDR_OPT, opt, 0);
      cmp("ext_clk_sel", opt[3:0] == 0, ext_clk_sel);
      cmp("xrc_enable", opt[3:0] > 4, xrc_enable);
      cmp("irc_enable", opt[3:0] > 0 && opt[3:0] < 5, irc_enable);
      if (opt[3:0] != 0)
        cmp("freq_band", (opt[3:0] - 1) % 4, freq_band);
      cmp("osc_cap_en", opt[6], osc_cap_en);
      sleep_req <= 1;
      @(posedge pclk);
      sleep_req <= 0;
      wait_clk(0, c);
      @(posedge pclk);
      wake_req <= 1;
      @(posedge pclk);
      wake_req <= 0;
      wait_clk(1, c);
      @(posedge pclk);
      n = (opt[3:0] > 4 && k != 9) ? 18 : 6;
      p = (opt[3:0] == 0) ? 2 : (opt[3:0] < 5) ? 3 : 4;
      cmp("wake cycles", 1, c >= n * p - p && c <= n * p + p + 4);
    end
    // Second reset in mid-run reloads the calibration byte
    presetn <= 0;
    calib_byte_hi <= 8'($random(seed));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    wait_clk(1, c);
    cmp("start cycles", 1, c >= DL + 12 && c <= DL + 26);
    cmp("trim_value", calib_byte_hi, trim_value);
    end_sim();
  end
endmodule
`default_nettype wire
